// ### logic/pacc_pkg.sv
// Package for the pulse accumulator and timer flag group two block.
// Assumes a 50 MHz bus clock and APB register access with 32-bit data.
package pacc_pkg;
    // ==========================================================
    // Register byte addresses (index times four)
    localparam int unsigned IDX_MASK_TWO  = 'h24;
    localparam int unsigned IDX_FLAGS_TWO = 'h25;
    localparam int unsigned IDX_CONTROL   = 'h26;
    localparam int unsigned IDX_COUNT     = 'h27;
    localparam logic [11:0] ADDR_MASK_TWO  = 12'(IDX_MASK_TWO * 4);
    localparam logic [11:0] ADDR_FLAGS_TWO = 12'(IDX_FLAGS_TWO * 4);
    localparam logic [11:0] ADDR_CONTROL   = 12'(IDX_CONTROL * 4);
    localparam logic [11:0] ADDR_COUNT     = 12'(IDX_COUNT * 4);
    // ==========================================================
    // Field positions
    localparam int BIT_WRAP    = 7;
    localparam int BIT_TICK    = 6;
    localparam int BIT_OVF     = 5;
    localparam int BIT_EDGE    = 4;
    localparam int BIT_ENABLE  = 6;
    localparam int BIT_GATED   = 5;
    localparam int BIT_EDGESEL = 4;
    localparam int BIT_SHARE   = 2;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'hF0;
    localparam logic [7:0] MASK_IMPL_MASK = 8'hF3;
    localparam logic [7:0] CTRL_IMPL_MASK = 8'h77;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MASK_TWO  = 8'h00;
    localparam logic [7:0] RST_FLAGS_TWO = 8'h00;
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    // ==========================================================
    // Timing
    localparam int TICK_BASE_LOG2 = 13;
    localparam int GATE_DIV       = 64;
    localparam int TICK_DIV_W     = TICK_BASE_LOG2 + 3;

    typedef struct packed {
        logic       enable;
        logic       gated;
        logic       edgeSel;
        logic       shareSel;
        logic [1:0] rateSel;
    } pacc_ctrl_t;
endpackage

// ### logic/pacc_top.sv
// Pulse accumulator, timer flag group two and periodic tick divider.
// Assumes an APB master on clk; pulse input is asynchronous to clk.
// Function
// - Flags clear only on written ones
// - Timer wrap sets flag bit 7
// - Each periodic interval sets tick flag
// - Flag bits three to zero read zero
// - Masked-on flag raises interrupt request
// - Tick from clock over two^13
// - Control bits 7 and 3 read zero
// - Eight-bit counter, event or gated mode
// - Gated mode counts clock over 64
// - Edge select picks falling or rising
// - Edge select picks inhibiting level
// - Enable bit activates accumulator
// - Share bit picks capture or compare
// - Counter survives reset, always accessible
// - Counter readable while gated off
// - Increments never collide with reads
// - Counter rollover sets overflow flag
// - Rate bits select 2^13 to 2^16
// - Interval timed from previous timeout
// - First flag after full interval
// - Selected edge sets edge flag
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pacc_top
    import pacc_pkg::*;
#(
    parameter int TICK_SHIFT = TICK_BASE_LOG2   // Shorten for simulation
) (
    input  wire logic        clk,         // Bus clock, 50 MHz
    input  wire logic        rst_n,       // Synchronous reset, low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic        timerWrap,   // Pulse from main timer wrap
    input  wire logic        pulseInput,  // External pulse pin
    output logic             irqReq,      // Interrupt request
    output logic             captureSel   // High: capture four, low: compare five
);
    import pacc_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0]  maskReg, flagsReg, ctrlReg, countReg;
    logic [7:0]  flagsNext, countNext;
    logic [1:0]  pinSync;
    logic        pinPrev;
    logic [15:0] tickDivReg;
    logic [5:0]  gateDivReg;
    logic        wrBusyReg;
    pacc_ctrl_t  ctrl;

    assign ctrl = '{enable: ctrlReg[BIT_ENABLE], gated: ctrlReg[BIT_GATED],
                    edgeSel: ctrlReg[BIT_EDGESEL], shareSel: ctrlReg[BIT_SHARE],
                    rateSel: ctrlReg[1:0]};

    // ==========================================================
    // APB decode: no wait state; read data is taken in setup, writes land in the access cycle
    wire access   = psel && penable && wrBusyReg;
    wire hitMask  = paddr == ADDR_MASK_TWO;
    wire hitFlags = paddr == ADDR_FLAGS_TWO;
    wire hitCtrl  = paddr == ADDR_CONTROL;
    wire hitCount = paddr == ADDR_COUNT;
    wire hitAny   = hitMask | hitFlags | hitCtrl | hitCount;
    wire wrEn     = access && pwrite && hitAny;
    wire [7:0] wByte = pwdata[7:0];
    wire [7:0] rdByte = hitMask  ? maskReg :
                        hitFlags ? (flagsReg & FLAG_IMPL_MASK) :
                        hitCtrl  ? (ctrlReg & CTRL_IMPL_MASK) :
                        hitCount ? countReg : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrBusyReg <= 1'b0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
        end else begin
            wrBusyReg <= psel && !penable;
            pready    <= psel && !penable;
            pslverr   <= psel && !penable && !hitAny;
            prdata    <= (psel && !penable && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Periodic tick: free-running, restarts at each timeout and with reset
    wire [15:0] tickLen = 16'(1) << (TICK_SHIFT + int'(ctrl.rateSel));
    wire        tickHit = (tickDivReg >= tickLen - 16'h0001);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickDivReg <= 16'h0000;
        end else if (tickHit) begin
            tickDivReg <= 16'h0000;
        end else begin
            tickDivReg <= tickDivReg + 16'h0001;
        end
    end

    // ==========================================================
    // Pulse input sync, edge and gate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gateDivReg <= 6'h00;
        end else begin
            gateDivReg <= gateDivReg + 6'h01;
        end
    end

    // No reset on the sampler: a pin idling high must not look like an edge
    always_ff @(posedge clk) begin
        pinSync <= {pinSync[0], pulseInput};
        pinPrev <= pinSync[1];
    end

    wire pin      = pinSync[1];
    // Input may toggle at most at half the clock; faster pulses are missed
    wire edgeSeen = ctrl.edgeSel ? (pin && !pinPrev) : (!pin && pinPrev);
    wire gateOpen = ctrl.edgeSel ? !pin : pin;
    wire gateTick = gateDivReg == 6'(GATE_DIV - 1);
    wire evEdge   = ctrl.enable && edgeSeen;
    wire bump     = ctrl.enable && (ctrl.gated ? (gateOpen && gateTick) : edgeSeen);
    wire rollOver = bump && countReg == 8'hFF;

    // ==========================================================
    // Counter: no reset; a bus write takes priority over an increment
    always_comb begin
        countNext = countReg;
        if (wrEn && hitCount) begin
            countNext = wByte;
        end else if (bump) begin
            countNext = countReg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        countReg <= countNext;
    end

    // ==========================================================
    // Flags: set wins over a simultaneous clear
    wire [7:0] setVec = {timerWrap, tickHit, rollOver, evEdge, 4'h0};
    wire [7:0] clrVec = (wrEn && hitFlags) ? wByte : 8'h00;
    assign flagsNext = ((flagsReg & ~clrVec) | setVec) & FLAG_IMPL_MASK;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            maskReg  <= RST_MASK_TWO;
            flagsReg <= RST_FLAGS_TWO;
            ctrlReg  <= RST_CONTROL;
            irqReq   <= 1'b0;
            captureSel <= 1'b0;
        end else begin
            flagsReg <= flagsNext;
            if (wrEn && hitMask) begin
                maskReg <= wByte & MASK_IMPL_MASK;
            end
            if (wrEn && hitCtrl) begin
                ctrlReg <= wByte & CTRL_IMPL_MASK;
            end
            irqReq     <= |(flagsNext & maskReg & FLAG_IMPL_MASK);
            captureSel <= (wrEn && hitCtrl) ? wByte[BIT_SHARE] : ctrl.shareSel;
        end
    end

    // ==========================================================
    // Check helpers
    // The counter has no reset, so count checks wait for its first write
    logic countKnownReg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            countKnownReg <= 1'b0;
        end else if (wrEn && hitCount) begin
            countKnownReg <= 1'b1;
        end
    end

    wire countWr = wrEn && hitCount;

    // ==========================================================
    // Checks: bus handshake, read data and register writes
    a_ready_after_setup: assert property (
        @(posedge clk) disable iff (!rst_n)
        (psel && !penable)
        |=> pready)
        else $error("ready missing after setup");

    a_ready_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready
        |=> !pready)
        else $error("ready held too long");

    a_slverr_with_ready: assert property (
        @(posedge clk) disable iff (!rst_n)
        pslverr
        |-> pready)
        else $error("error without ready");

    a_rdata_idle_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        !pready
        |-> prdata == 32'h0000_0000)
        else $error("read data outside transfer");

    a_rdata_upper_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        pready
        |-> prdata[31:8] == 24'h000000)
        else $error("upper read data set");

    a_flags_read_value: assert property (
        @(posedge clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && hitFlags)
        |=> prdata[7:0] == ($past(flagsReg) & FLAG_IMPL_MASK))
        else $error("flag read value wrong");

    a_count_read_value: assert property (
        @(posedge clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && hitCount && countKnownReg)
        |=> prdata[7:0] == $past(countReg))
        else $error("count read value wrong");

    a_mask_write_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrEn && hitMask)
        |=> maskReg == ($past(wByte) & MASK_IMPL_MASK))
        else $error("mask write lost");

    a_ctrl_write_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrEn && hitCtrl)
        |=> ctrlReg == ($past(wByte) & CTRL_IMPL_MASK))
        else $error("control write lost");

    a_low_bits_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        flagsReg[3:0] == 4'h0
        && ctrlReg[7] == 1'b0 && ctrlReg[3] == 1'b0)
        else $error("unimplemented bits set");

    a_share_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        captureSel ==
        ctrlReg[BIT_SHARE])
        else $error("share select mismatch");

    // ==========================================================
    // Checks: flags, interrupt request and tick divider
    a_flag_clear_one: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrEn && hitFlags && wByte[BIT_OVF] && !rollOver)
        |=> !flagsReg[BIT_OVF])
        else $error("overflow flag not cleared");

    a_flag_keep_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wrEn && hitFlags && !wByte[BIT_EDGE] && flagsReg[BIT_EDGE])
        |=> flagsReg[BIT_EDGE])
        else $error("edge flag lost on zero write");

    a_no_stray_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setVec == 8'h00)
        |=> (flagsReg & ~$past(flagsReg)) == 8'h00)
        else $error("flag set without event");

    a_wrap_sets: assert property (
        @(posedge clk) disable iff (!rst_n)
        timerWrap
        |=> flagsReg[BIT_WRAP])
        else $error("wrap flag missing");

    a_tick_sets: assert property (
        @(posedge clk) disable iff (!rst_n)
        tickHit
        |=> flagsReg[BIT_TICK])
        else $error("tick flag missing");

    a_irq_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        irqReq ==
        $past(|(flagsNext & maskReg)))
        else $error("irq mismatch");

    a_irq_masked_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((maskReg & FLAG_IMPL_MASK) == 8'h00)
        |=> !irqReq)
        else $error("irq with all enables off");

    a_overflow_sets: assert property (
        @(posedge clk) disable iff (!rst_n)
        rollOver
        |=> flagsReg[BIT_OVF])
        else $error("overflow flag missing");

    a_edge_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        evEdge
        |=> flagsReg[BIT_EDGE])
        else $error("edge flag missing");

    a_disabled_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!ctrl.enable && !flagsReg[BIT_EDGE] && !flagsReg[BIT_OVF])
        |=> !flagsReg[BIT_EDGE] && !flagsReg[BIT_OVF])
        else $error("flag set while disabled");

    a_first_tick: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n)
        |-> tickDivReg == 16'h0000)
        else $error("tick divider not restarted");

    a_tick_restart: assert property (
        @(posedge clk) disable iff (!rst_n)
        tickHit
        |=> tickDivReg == 16'h0000)
        else $error("tick divider not cleared");

    a_tick_free_run: assert property (
        @(posedge clk) disable iff (!rst_n)
        !tickHit
        |=> tickDivReg == $past(tickDivReg) + 16'h0001)
        else $error("tick divider stalled");

    // ==========================================================
    // Checks: counter and gate divider
    a_count_write_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        countWr
        |=> countReg == $past(wByte))
        else $error("count write lost");

    a_overflow_roll: assert property (
        @(posedge clk) disable iff (!rst_n)
        (bump && countReg == 8'hFF && !countWr)
        |=> countReg == 8'h00 && flagsReg[BIT_OVF])
        else $error("rollover not flagged");

    a_event_bump: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctrl.enable && !ctrl.gated && edgeSeen && countKnownReg && !countWr)
        |=> countReg == $past(countReg) + 8'h01)
        else $error("edge not counted");

    a_gated_bump: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctrl.enable && ctrl.gated && gateOpen && gateTick && countKnownReg && !countWr)
        |=> countReg == $past(countReg) + 8'h01)
        else $error("gated tick not counted");

    a_gated_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctrl.enable && ctrl.gated && !gateTick && countKnownReg && !countWr)
        |=> $stable(countReg))
        else $error("gated count off divider");

    a_gate_shut: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctrl.enable && ctrl.gated && !gateOpen && countKnownReg && !countWr)
        |=> $stable(countReg))
        else $error("count moved while inhibited");

    a_disabled_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!ctrl.enable && countKnownReg && !countWr)
        |=> $stable(countReg))
        else $error("counter moved while disabled");

    a_gate_div_wrap: assert property (
        @(posedge clk) disable iff (!rst_n)
        gateTick
        |=> gateDivReg == 6'h00)
        else $error("gate divider not wrapped");
endmodule // pacc_top
`default_nettype wire

// ### verif/pacc_pulse_src.sv
// Far-side model: source driving the external pulse pin.
// Assumes the testbench starts bursts with start and sets the idle level.
`timescale 1ns/1ps
`default_nettype none
module pacc_pulse_src (
    input  wire logic       clk,      // Bus clock
    input  wire logic       start,    // Load a burst
    input  wire logic [7:0] toggles,  // Pin toggles in the burst
    input  wire logic       idleLvl,  // Level held outside bursts
    output var  logic       pulse,    // Pin level
    output logic            busy      // Burst in progress
);
    // ==========================================================
    // Burst engine
    logic [7:0] left = 8'h00;
    logic       ph   = 1'b0;
    assign busy = (left != 8'h00);
    // Half period of two clocks keeps the pin below clk/2
    always @(posedge clk) begin
        if (start) begin
            left <= toggles;
            ph   <= 1'b0;
        end else if (busy) begin
            ph <= ~ph;
            if (ph) begin
                pulse <= ~pulse;
                left  <= left - 8'h01;
            end
        end else begin
            pulse <= idleLvl;
        end
    end
endmodule // pacc_pulse_src
`default_nettype wire

// ### verif/pulse_accumulator_rti_flags_tb_top.sv
// Testbench: APB register tests of the pulse accumulator block.
// Assumes pacc_pkg constants and the pulse source model.
`timescale 1ns/1ps
`default_nettype none
module pulse_accumulator_rti_flags_tb_top;
    import pacc_pkg::*;
    localparam int TS = 4;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, timerWrap = 0, pulseInput, irqReq, captureSel;
    logic go = 0, idleLvl = 0, busy, err;
    logic [7:0] tog = '0, v, c1;
    int numErrors = 0, checked = 0, cyc = 0, t0;
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    pacc_top #(.TICK_SHIFT(TS)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerWrap(timerWrap),
        .pulseInput(pulseInput), .irqReq(irqReq), .captureSel(captureSel));
    pacc_pulse_src i_src (.clk(clk), .start(go), .toggles(tog), .idleLvl(idleLvl),
        .pulse(pulseInput), .busy(busy));
    // ==========================================================
    // Bus and check tasks
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        v = prdata[7:0];
        err = pslverr;
        psel <= 0; penable <= 0;
        // Spare edge lets the write's side effects settle
        @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic burst(input logic [7:0] n);
        @(posedge clk);
        go <= 1; tog <= n;
        @(posedge clk);
        go <= 0;
        @(posedge clk);
        for (int i = 0; i < 100 && busy; i++) @(posedge clk);
        repeat (5) @(posedge clk);
    endtask
    task automatic waitIrq;
        for (int i = 0; i < 300 && irqReq !== 1'b1; i++) @(posedge clk);
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        xfer(0, ADDR_FLAGS_TWO, 0); chk("flags", v, RST_FLAGS_TWO);
        xfer(0, ADDR_MASK_TWO, 0); chk("mask", v, RST_MASK_TWO);
        xfer(0, ADDR_CONTROL, 0); chk("ctrl", v, RST_CONTROL);
        // Counter is undefined after reset; load it before anything counts
        xfer(1, ADDR_COUNT, 8'h00); xfer(0, ADDR_COUNT, 0); chk("count", v, 8'h00);
        xfer(1, ADDR_CONTROL, 8'hFF); xfer(0, ADDR_CONTROL, 0);
        chk("ctrl", v, CTRL_IMPL_MASK);
        chk("share", {7'h0, captureSel}, 8'h01);
        xfer(1, ADDR_MASK_TWO, 8'hFF); xfer(0, ADDR_MASK_TWO, 0); chk("mask", v, 8'hF3);
        xfer(0, 12'h0A0, 0); chk("slverr", {7'h0, err}, 8'h01);
        chk("unmapped", v, 8'h00);
        $display("register test done");
        xfer(1, ADDR_MASK_TWO, 8'h80);
        @(posedge clk) timerWrap <= 1;
        @(posedge clk) timerWrap <= 0;
        xfer(1, ADDR_FLAGS_TWO, 8'h7F); xfer(0, ADDR_FLAGS_TWO, 0);
        chk("wrap", v & 8'hBF, 8'h80);
        chk("irq", {7'h0, irqReq}, 8'h01);
        xfer(1, ADDR_FLAGS_TWO, 8'h8F); xfer(0, ADDR_FLAGS_TWO, 0);
        chk("clear", v & 8'hBF, 8'h00);
        chk("irq", {7'h0, irqReq}, 8'h00);
        $display("flag test done");
        xfer(1, ADDR_CONTROL, 8'h50); xfer(1, ADDR_COUNT, 8'hFE);
        burst(4); xfer(0, ADDR_COUNT, 0); chk("rise", v, 8'h00);
        xfer(0, ADDR_FLAGS_TWO, 0); chk("ovf", v & 8'h30, 8'h30);
        xfer(1, ADDR_CONTROL, 8'h40); xfer(1, ADDR_COUNT, 8'h00);
        burst(4); xfer(0, ADDR_COUNT, 0); chk("fall", v, 8'h02);
        xfer(1, ADDR_FLAGS_TWO, 8'h30); xfer(1, ADDR_CONTROL, 8'h00);
        chk("share", {7'h0, captureSel}, 8'h00);
        burst(4); xfer(0, ADDR_COUNT, 0); chk("hold", v, 8'h02);
        xfer(0, ADDR_FLAGS_TWO, 0); chk("quiet", v & 8'h30, 8'h00);
        $display("event test done");
        idleLvl <= 1;
        xfer(1, ADDR_CONTROL, 8'h60); xfer(1, ADDR_COUNT, 8'h00);
        repeat (256) @(posedge clk);
        xfer(0, ADDR_COUNT, 0); chk("gated", {7'h0, v >= 3 && v <= 5}, 8'h01);
        idleLvl <= 0;
        repeat (8) @(posedge clk);
        xfer(0, ADDR_COUNT, 0); c1 = v;
        repeat (200) @(posedge clk);
        xfer(0, ADDR_COUNT, 0); chk("inhibit", v, c1);
        $display("gated test done");
        // Flag pending from before a rate change is dropped; timing runs from the first timeout after it
        xfer(1, ADDR_MASK_TWO, 8'h40);
        for (int r = 0; r < 4; r++) begin
            xfer(1, ADDR_CONTROL, 8'(r));
            waitIrq; xfer(1, ADDR_FLAGS_TWO, 8'h40);
            waitIrq; t0 = cyc; xfer(1, ADDR_FLAGS_TWO, 8'h40);
            waitIrq; chk("tick", 8'(cyc - t0), 8'(1 << (TS + r)));
        end
        $display("tick test done");
        tallyAndFinish;
    end
    initial begin
        #1000000;
        numErrors++;
        tallyAndFinish;
    end
endmodule // pulse_accumulator_rti_flags_tb_top
`default_nettype wire
